// ---- hdl/tms_event_flags.sv ----
`timescale 1ns/1ps
`include "tms_defines.svh"

module tms_event_flags
    import tms_pkg::*;
#(
    parameter int NUM_EVENTS = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // events and clearing
    input wire logic [NUM_EVENTS-1:0] event_pulse,
    input wire logic clear_on_read,
    input wire logic [NUM_EVENTS-1:0] enable,
    // state
    output logic [NUM_EVENTS-1:0] flags,
    output logic irq
);

    logic [NUM_EVENTS-1:0] next_flags;

    if (NUM_EVENTS < 1 || NUM_EVENTS > 32) begin : g_bad_events
        $error("tms_event_flags: NUM_EVENTS out of range");
    end

    // ----------------------------------------
    // one sticky flag per event
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < NUM_EVENTS; i++) begin : g_flag
            // set wins over read clear
            assign next_flags[i] = event_pulse[i] || (flags[i] && !clear_on_read);
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (reset) begin
            flags <= NUM_EVENTS'(`TMS_RST_FLAGS);
        end else if (clk_en) begin
            flags <= next_flags;
        end
    end

    assign irq = |(flags & enable);

    property p_set_wins;
        @(posedge clk) disable iff (reset)
        clk_en && event_pulse[0] |=> flags[0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event flag not set");

    property p_irq_masked;
        @(posedge clk) disable iff (reset)
        (flags & enable) == '0 |-> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq without enabled flag");

endmodule

// ---- hdl/tms_timer_status.sv ----
// How it works
// - Overflow of the 16-bit up-counter sets status bit 2, which is zero otherwise.
// - A count equal to compare value b sets status bit 1.
// - A count equal to compare value a sets status bit 0.
// - Reading the status register clears the flags it returns; writes never clear.
// - The interrupt line rises only for flags whose enable bit is set.
// - Flags are set on their events whatever the enable bits hold.
// - Enable bit 2 gates the overflow interrupt, read-write, reset zero.
// - Enable bit 1 gates the compare b interrupt.
// - Enable bit 0 gates the compare a interrupt.
// - Reading the counter readout returns the count of that moment in bits 15 to 0.
// - Two read-write 16-bit compare values, reset zero, are compared all the time.
// - With clear enable set a compare b match clears the counter, otherwise not.
// - Captured value a holds the count taken at a capture event, upper bits zero.

`timescale 1ns/1ps
`include "tms_defines.svh"

module tms_timer_status
    import tms_pkg::*;
#(
    parameter int COUNT_WIDTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // counter tick and capture
    input wire logic count_tick,
    input wire logic capture_a,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // status outputs
    output logic [COUNT_WIDTH-1:0] count,
    output logic irq
);

    if (COUNT_WIDTH < 2 || COUNT_WIDTH > 32) begin : g_bad_width
        $error("tms_timer_status: COUNT_WIDTH out of range");
    end

    localparam logic [COUNT_WIDTH-1:0] COUNT_MAX = '1;
    localparam logic [1:0] CONTROL_RST = `TMS_RST_CONTROL;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [COUNT_WIDTH-1:0] compare_field_a;
    logic [COUNT_WIDTH-1:0] compare_field_b;
    logic [COUNT_WIDTH-1:0] captured_field_a;
    logic [2:0] interrupt_enable;
    logic run;
    logic counter_clear_enable;
    logic [2:0] event_flags;
    logic [2:0] event_pulse;
    logic match_a;
    logic match_b;
    logic wrap;
    logic status_read;
    logic wr_compare_a;
    logic wr_compare_b;
    logic wr_enable;
    logic wr_control;

    assign wr_compare_a = reg_write && reg_addr == `TMS_OFS_COMPARE_A;
    assign wr_compare_b = reg_write && reg_addr == `TMS_OFS_COMPARE_B;
    assign wr_enable = reg_write && reg_addr == `TMS_OFS_IRQ_ENABLE;
    assign wr_control = reg_write && reg_addr == `TMS_OFS_CONTROL;
    assign status_read = reg_read && reg_addr == `TMS_OFS_EVENT_FLAGS;

    always_ff @(posedge clk) begin
        if (reset) begin
            compare_field_a <= COUNT_WIDTH'(`TMS_RST_COMPARE);
            compare_field_b <= COUNT_WIDTH'(`TMS_RST_COMPARE);
        end else if (clk_en) begin
            if (wr_compare_a) begin
                compare_field_a <= reg_wdata[COUNT_WIDTH-1:0];
            end
            if (wr_compare_b) begin
                compare_field_b <= reg_wdata[COUNT_WIDTH-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            interrupt_enable <= `TMS_RST_MASK;
            run <= CONTROL_RST[`TMS_BIT_RUN];
            counter_clear_enable <= CONTROL_RST[`TMS_BIT_CLEAR_ENABLE];
        end else if (clk_en) begin
            if (wr_enable) begin
                interrupt_enable <= reg_wdata[2:0];
            end
            if (wr_control) begin
                run <= reg_wdata[`TMS_BIT_RUN];
                counter_clear_enable <= reg_wdata[`TMS_BIT_CLEAR_ENABLE];
            end
        end
    end

    // ----------------------------------------
    // up-counter and events
    // ----------------------------------------
    assign match_a = count == compare_field_a;
    assign match_b = count == compare_field_b;
    assign wrap = run && count_tick && count == COUNT_MAX;

    always_ff @(posedge clk) begin
        if (reset) begin
            count <= '0;
        end else if (clk_en) begin
            if (!run) begin
                count <= '0;
            end else if (count_tick) begin
                if (counter_clear_enable && match_b) begin
                    count <= '0;
                end else begin
                    count <= count + 1'b1;
                end
            end
        end
    end

    // match events only on a tick so a standing equality sets once
    always_comb begin
        event_pulse = '0;
        event_pulse[`TMS_BIT_MATCH_A] = run && count_tick && match_a;
        event_pulse[`TMS_BIT_MATCH_B] = run && count_tick && match_b;
        event_pulse[`TMS_BIT_OVERFLOW] = wrap && !(counter_clear_enable && match_b);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            captured_field_a <= COUNT_WIDTH'(`TMS_RST_CAPTURE);
        end else if (clk_en && capture_a) begin
            captured_field_a <= count;
        end
    end

    tms_event_flags #(
        .NUM_EVENTS(3)
    ) tms_event_flags_i (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .event_pulse(event_pulse),
        .clear_on_read(status_read),
        .enable(interrupt_enable),
        .flags(event_flags),
        .irq(irq)
    );

    // ----------------------------------------
    // read data, one cycle after the strobe
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (clk_en) begin
            reg_rdata <= '0;
            if (reg_read) begin
                case (reg_addr)
                    `TMS_OFS_EVENT_FLAGS: reg_rdata <= {29'h0, event_flags};
                    `TMS_OFS_IRQ_ENABLE: reg_rdata <= {29'h0, interrupt_enable};
                    `TMS_OFS_COUNTER_READOUT: reg_rdata <= 32'(count);
                    `TMS_OFS_COMPARE_A: reg_rdata <= 32'(compare_field_a);
                    `TMS_OFS_COMPARE_B: reg_rdata <= 32'(compare_field_b);
                    `TMS_OFS_CAPTURED_A: reg_rdata <= 32'(captured_field_a);
                    `TMS_OFS_CONTROL: reg_rdata <= {30'h0, counter_clear_enable, run};
                    default: reg_rdata <= '0;
                endcase
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_overflow;
        @(posedge clk) disable iff (reset)
        clk_en && run && count_tick && count == COUNT_MAX && !(counter_clear_enable && match_b)
            |=> event_flags[2] && count == '0;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not flagged");

    property p_match_b;
        @(posedge clk) disable iff (reset)
        clk_en && run && count_tick && count == compare_field_b |=> event_flags[1];
    endproperty
    a_match_b: assert property (p_match_b) else $error("match b not flagged");

    property p_match_a;
        @(posedge clk) disable iff (reset)
        clk_en && run && count_tick && count == compare_field_a |=> event_flags[0];
    endproperty
    a_match_a: assert property (p_match_a) else $error("match a not flagged");

    property p_read_clears;
        @(posedge clk) disable iff (reset)
        clk_en && status_read && event_pulse == '0 |=> event_flags == '0;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear");

    property p_write_keeps;
        @(posedge clk) disable iff (reset)
        clk_en && reg_write && !reg_read && event_flags[0] |=> event_flags[0];
    endproperty
    a_write_keeps: assert property (p_write_keeps) else $error("write cleared flag");

    property p_irq;
        @(posedge clk) disable iff (reset)
        irq == |(event_flags & interrupt_enable);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt gating wrong");

    property p_readout;
        @(posedge clk) disable iff (reset)
        clk_en && reg_read && reg_addr == `TMS_OFS_COUNTER_READOUT
            |=> reg_rdata == 32'($past(count));
    endproperty
    a_readout: assert property (p_readout) else $error("counter readout wrong");

    property p_clear_on_b;
        @(posedge clk) disable iff (reset)
        clk_en && run && count_tick && counter_clear_enable && match_b |=> count == '0;
    endproperty
    a_clear_on_b: assert property (p_clear_on_b) else $error("counter not cleared");

    property p_capture;
        @(posedge clk) disable iff (reset)
        clk_en && capture_a ##1 clk_en && reg_read && reg_addr == `TMS_OFS_CAPTURED_A
            |=> reg_rdata == 32'($past(count, 2));
    endproperty
    a_capture: assert property (p_capture) else $error("capture value wrong");

    // ----------------------------------------
    // checks: holding, freezing, read data
    // ----------------------------------------
    property p_freeze;
        @(posedge clk) disable iff (reset)
        !clk_en |=> $stable(count) && $stable(event_flags) && $stable(reg_rdata);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

    property p_rdata_idle;
        @(posedge clk) disable iff (reset)
        clk_en && !reg_read |=> reg_rdata == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not back to zero");

    property p_stopped;
        @(posedge clk) disable iff (reset)
        clk_en && !run |=> count == '0;
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped counter not zero");

    property p_count_step;
        @(posedge clk) disable iff (reset)
        clk_en && run && count_tick && !(counter_clear_enable && match_b)
            |=> count == $past(count) + 1'b1;
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter did not step");

    property p_no_clear;
        @(posedge clk) disable iff (reset)
        clk_en && run && count_tick && !counter_clear_enable && count != COUNT_MAX
            |=> count != '0;
    endproperty
    a_no_clear: assert property (p_no_clear) else $error("counter cleared");

    property p_set_masked;
        @(posedge clk) disable iff (reset)
        clk_en && event_pulse != '0
            |=> (event_flags & $past(event_pulse)) == $past(event_pulse);
    endproperty
    a_set_masked: assert property (p_set_masked) else $error("event lost its flag");

    property p_ovf_quiet;
        @(posedge clk) disable iff (reset)
        clk_en && !event_pulse[`TMS_BIT_OVERFLOW] && !event_flags[`TMS_BIT_OVERFLOW]
            |=> !event_flags[`TMS_BIT_OVERFLOW];
    endproperty
    a_ovf_quiet: assert property (p_ovf_quiet) else $error("stray overflow flag");

    property p_flags_report;
        @(posedge clk) disable iff (reset)
        clk_en && status_read |=> reg_rdata == {29'h0, $past(event_flags)};
    endproperty
    a_flags_report: assert property (p_flags_report) else $error("status read wrong");

    property p_mask_report;
        @(posedge clk) disable iff (reset)
        clk_en && reg_read && reg_addr == `TMS_OFS_IRQ_ENABLE
            |=> reg_rdata == {29'h0, $past(interrupt_enable)};
    endproperty
    a_mask_report: assert property (p_mask_report) else $error("enable read wrong");

    property p_enable_hold;
        @(posedge clk) disable iff (reset)
        !wr_enable |=> $stable(interrupt_enable);
    endproperty
    a_enable_hold: assert property (p_enable_hold) else $error("enable changed");

    property p_compare_hold;
        @(posedge clk) disable iff (reset)
        !wr_compare_a && !wr_compare_b
            |=> $stable(compare_field_a) && $stable(compare_field_b);
    endproperty
    a_compare_hold: assert property (p_compare_hold) else $error("compare changed");

    property p_capture_take;
        @(posedge clk) disable iff (reset)
        clk_en && capture_a |=> captured_field_a == $past(count);
    endproperty
    a_capture_take: assert property (p_capture_take) else $error("capture missed");

    property p_capture_hold;
        @(posedge clk) disable iff (reset)
        !capture_a |=> $stable(captured_field_a);
    endproperty
    a_capture_hold: assert property (p_capture_hold) else $error("capture changed");

    property p_irq_ovf;
        @(posedge clk) disable iff (reset)
        event_flags[`TMS_BIT_OVERFLOW] && interrupt_enable[`TMS_BIT_OVERFLOW] |-> irq;
    endproperty
    a_irq_ovf: assert property (p_irq_ovf) else $error("overflow interrupt missing");

    property p_irq_b;
        @(posedge clk) disable iff (reset)
        event_flags[`TMS_BIT_MATCH_B] && interrupt_enable[`TMS_BIT_MATCH_B] |-> irq;
    endproperty
    a_irq_b: assert property (p_irq_b) else $error("match b interrupt missing");

    property p_irq_a;
        @(posedge clk) disable iff (reset)
        event_flags[`TMS_BIT_MATCH_A] && interrupt_enable[`TMS_BIT_MATCH_A] |-> irq;
    endproperty
    a_irq_a: assert property (p_irq_a) else $error("match a interrupt missing");

endmodule

// ---- include/tms_defines.svh ----
`ifndef TMS_DEFINES_SVH
`define TMS_DEFINES_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define TMS_OFS_EVENT_FLAGS 8'h00
`define TMS_OFS_IRQ_ENABLE 8'h04
`define TMS_OFS_COUNTER_READOUT 8'h08
`define TMS_OFS_COMPARE_A 8'h0c
`define TMS_OFS_COMPARE_B 8'h10
`define TMS_OFS_CAPTURED_A 8'h14
`define TMS_OFS_CONTROL 8'h18

// ----------------------------------------
// field positions
// ----------------------------------------
`define TMS_BIT_MATCH_A 0
`define TMS_BIT_MATCH_B 1
`define TMS_BIT_OVERFLOW 2
`define TMS_BIT_RUN 0
`define TMS_BIT_CLEAR_ENABLE 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define TMS_RST_FLAGS 3'h0
`define TMS_RST_MASK 3'h0
`define TMS_RST_COMPARE 16'h0000
`define TMS_RST_CAPTURE 16'h0000
`define TMS_RST_CONTROL 2'h0

`endif

// ---- include/tms_pkg.sv ----
package tms_pkg;
    typedef logic [2:0] tms_event_t;
    typedef logic [15:0] tms_count_t;
endpackage

// ---- test/tms_timer_status_tb_top.sv ----
`timescale 1ns/1ps
`include "tms_defines.svh"

module tms_timer_status_tb_top
    import tms_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic count_tick = 1'b0;
    logic capture_a = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata;
    tms_count_t count;
    logic irq;
    int miscompares = 0;
    int comparisons = 0;
    logic [15:0] seed = 16'h003e;
    logic [31:0] rd;
    logic [31:0] val;

    always #5 clk = ~clk;

    tms_timer_status tms_timer_status_i (
        .clk(clk), .reset(reset), .clk_en(clk_en),
        .count_tick(count_tick), .capture_a(capture_a),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .count(count), .irq(irq)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // 16-bit register read back: low half kept, upper half zero
    function automatic logic [31:0] exp_reg16(input logic [31:0] d);
        return {16'h0, d[15:0]};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask

    task automatic rdreg(input logic [7:0] a);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            count_tick <= 1'b1;
        end
        @(posedge clk);
        count_tick <= 1'b0;
        #1;
    endtask

    task automatic stop_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    initial begin
        repeat (90000) @(posedge clk);
        miscompares++;
        stop_test();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        // reset values, unmapped place reads zero
        for (int a = 0; a <= 8'h1c; a += 4) begin
            rdreg(8'(a));
            check("reset value", rd, 32'h0);
        end
        wr(`TMS_OFS_IRQ_ENABLE, 32'hffffffff);
        rdreg(`TMS_OFS_IRQ_ENABLE);
        check("enable rw", rd, 32'h7);
        wr(`TMS_OFS_IRQ_ENABLE, 32'h0);
        // random compare readback, upper bits dropped
        for (int i = 0; i < 8; i++) begin
            seed = lfsr_next(seed);
            val = {seed, lfsr_next(seed)};
            wr(i[0] ? `TMS_OFS_COMPARE_B : `TMS_OFS_COMPARE_A, val);
            rdreg(i[0] ? `TMS_OFS_COMPARE_B : `TMS_OFS_COMPARE_A);
            check("compare rw", rd, exp_reg16(val));
        end
        wr(`TMS_OFS_COMPARE_A, 32'h5);
        wr(`TMS_OFS_COMPARE_B, 32'h9);
        wr(`TMS_OFS_CONTROL, 32'h1);
        tick(5);
        rdreg(`TMS_OFS_COUNTER_READOUT);
        check("readout", rd, 32'h5);
        check("count port", {16'h0, count}, 32'h5);
        @(posedge clk);
        #1;
        check("read data one cycle", reg_rdata, 32'h0);
        rdreg(`TMS_OFS_EVENT_FLAGS);
        check("flags before match", rd, 32'h0);
        tick(1);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(`TMS_OFS_IRQ_ENABLE, 32'h1);
        check("irq match a", {31'h0, irq}, 32'h1);
        wr(`TMS_OFS_EVENT_FLAGS, 32'h7);
        check("write no clear", {31'h0, irq}, 32'h1);
        rdreg(`TMS_OFS_EVENT_FLAGS);
        check("flag a", rd, 32'h1);
        check("irq after read", {31'h0, irq}, 32'h0);
        rdreg(`TMS_OFS_EVENT_FLAGS);
        check("flags cleared", rd, 32'h0);
        tick(4);
        check("irq b masked", {31'h0, irq}, 32'h0);
        wr(`TMS_OFS_IRQ_ENABLE, 32'h2);
        check("irq match b", {31'h0, irq}, 32'h1);
        rdreg(`TMS_OFS_EVENT_FLAGS);
        check("flag b", rd, 32'h2);
        rdreg(`TMS_OFS_COUNTER_READOUT);
        check("no clear", rd, 32'ha);
        // read right behind the capture pulse
        @(posedge clk);
        capture_a <= 1'b1;
        @(posedge clk);
        capture_a <= 1'b0;
        reg_read <= 1'b1;
        reg_addr <= `TMS_OFS_CAPTURED_A;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        check("captured", reg_rdata, 32'ha);
        wr(`TMS_OFS_CAPTURED_A, 32'h1234);
        rdreg(`TMS_OFS_CAPTURED_A);
        check("captured ro", rd, 32'ha);
        // clear on b match
        wr(`TMS_OFS_COMPARE_B, 32'hc);
        wr(`TMS_OFS_CONTROL, 32'h3);
        tick(3);
        rdreg(`TMS_OFS_COUNTER_READOUT);
        check("cleared on b", rd, 32'h0);
        rdreg(`TMS_OFS_EVENT_FLAGS);
        check("flag b clear", rd, 32'h2);
        // full wrap
        wr(`TMS_OFS_CONTROL, 32'h1);
        tick(65535);
        rdreg(`TMS_OFS_EVENT_FLAGS);
        check("no overflow yet", rd, 32'h3);
        tick(1);
        wr(`TMS_OFS_IRQ_ENABLE, 32'h4);
        check("irq overflow", {31'h0, irq}, 32'h1);
        wr(`TMS_OFS_IRQ_ENABLE, 32'h3);
        check("irq ovf masked", {31'h0, irq}, 32'h0);
        rdreg(`TMS_OFS_COUNTER_READOUT);
        check("wrapped", rd, 32'h0);
        rdreg(`TMS_OFS_EVENT_FLAGS);
        check("overflow flag", rd, 32'h4);
        // clock enable low freezes count and read data
        @(posedge clk);
        clk_en <= 1'b0;
        count_tick <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= `TMS_OFS_COMPARE_B;
        @(posedge clk);
        reg_read <= 1'b0;
        count_tick <= 1'b0;
        clk_en <= 1'b1;
        #1;
        check("frozen count", {16'h0, count}, 32'h0);
        check("frozen read", reg_rdata, 32'h0);
        // reset in mid-run
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1;
        check("reset irq", {31'h0, irq}, 32'h0);
        check("reset count", {16'h0, count}, 32'h0);
        rdreg(`TMS_OFS_IRQ_ENABLE);
        check("reset enable", rd, 32'h0);
        rdreg(`TMS_OFS_COMPARE_B);
        check("reset compare", rd, 32'h0);
        stop_test();
    end
endmodule
